/* File: config_load_port.sv */
// configuration data intake and daisy-chain forwarding port
`timescale 1ns/1ps
`include "config_load_cfg.svh"
module config_load_port (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        config_clock,
  input  config_load_pkg::mode_e           mode,
  input  wire logic                        config_done,
  input  wire logic                        config_error,
  input  wire logic                        ext_address_enable,
  input  config_load_pkg::host_pins_s      host_pins,
  input  wire logic [`CFG_BYTE_W-1:0]      config_byte_bus_in,
  output config_load_pkg::byte_drive_s     config_byte_bus,
  input  wire logic                        serial_data_in,
  output logic                             serial_data_out,
  output logic                             serial_data_out_oe,
  output config_load_pkg::prom_addr_s      prom_address,
  output logic                             init_n_out,
  output logic                             init_n_oe,
  output config_load_pkg::host_pins_s      user_pins,
  output config_load_pkg::byte_beat_s      loaded_byte
);

  ////////////////////////////////////////////////////////////////////////////
  // core-domain state, all but the fifo held in one record
  typedef struct packed {
    logic [`CFG_PIN_W-1:0]       pin_meta;
    logic [`CFG_PIN_W-1:0]       pin_sync;
    config_load_pkg::byte_t      data_meta;
    config_load_pkg::byte_t      data_sync;
    logic                        ws_prev;
    logic                        hold_valid;
    config_load_pkg::byte_t      hold_byte;
    config_load_pkg::byte_t      bus_out;
    config_load_pkg::byte_t      bus_oe;
    logic [`CFG_ADDR_FULL_W-1:0] addr;
    logic                        addr_oe;
    logic                        ext_oe;
    logic [`CFG_SETTLE_W-1:0]    settle;
    logic                        xfer_req;
    config_load_pkg::byte_t      xfer_byte;
    logic                        ack_meta;
    logic                        ack_sync;
    logic                        rx_meta;
    logic                        rx_sync;
    logic                        rx_seen;
    logic                        out_valid;
    config_load_pkg::byte_t      out_byte;
    logic                        init_low;
    logic                        dout_oe;
    logic [`CFG_PIN_W-1:0]       user_pins;
  } core_state_s;

  // link-domain state, clocked by the configuration clock
  typedef struct packed {
    logic                        rst_meta;
    logic                        rst_sync;
    logic [`CFG_MODE_W-1:0]      mode_meta;
    logic [`CFG_MODE_W-1:0]      mode_sync;
    logic                        done_meta;
    logic                        done_sync;
    logic                        req_meta;
    logic                        req_sync;
    logic                        req_seen;
    logic                        ack_tog;
    config_load_pkg::byte_t      shift;
    logic [`CFG_BIT_CNT_W-1:0]   shift_cnt;
    logic                        bit_d1;
    logic                        bit_d2;
    config_load_pkg::byte_t      asm_byte;
    logic [`CFG_BIT_CNT_W-1:0]   asm_cnt;
    config_load_pkg::byte_t      rx_byte;
    logic                        rx_tog;
  } link_state_s;

  core_state_s                 core_r;
  core_state_s                 core_nxt;
  link_state_s                 link_r;
  link_state_s                 link_nxt;
  logic                        dout_r;
  logic                        dout_nxt;

  config_load_pkg::host_pins_s pins;
  config_load_pkg::mode_e      link_mode;
  logic                        selected;
  logic                        ws_low;
  logic                        rs_low;
  logic                        wr_take;
  logic                        status_read;
  logic                        mode_parallel;
  logic                        mode_stream;
  logic                        fifo_in_ready;
  logic                        fifo_out_valid;
  logic                        fifo_out_ready;
  config_load_pkg::byte_t      fifo_out_data;

  ////////////////////////////////////////////////////////////////////////////
  // decode of the synchronised host pins
  assign pins = config_load_pkg::host_pins_s'(core_r.pin_sync);
  assign ws_low = !pins.write_strobe_n;
  assign rs_low = !pins.read_strobe_n;
  assign selected = !pins.select_active_low && pins.select_active_high
                    && (mode == config_load_pkg::MODE_PERIPHERAL) && !config_done;
  // only the falling edge loads, so a long strobe cannot load twice
  assign wr_take = selected && ws_low && !core_r.ws_prev && !core_r.hold_valid;
  // a write strobe masks a read strobe held at the same time
  assign status_read = selected && rs_low && !ws_low;

  // master parallel and peripheral modes forward through the link shifter
  assign mode_parallel = (mode == config_load_pkg::MODE_MASTER_PARALLEL)
                         || (mode == config_load_pkg::MODE_PERIPHERAL);
  assign mode_stream   = !mode_parallel;

  // drain waits for the link to accept the previous byte in master parallel and peripheral modes
  assign fifo_out_ready = mode_stream || (core_r.xfer_req == core_r.ack_sync);

  ////////////////////////////////////////////////////////////////////////////
  // byte buffer between intake and forwarding
  config_fifo #(
    .WIDTH (`CFG_BYTE_W),
    .DEPTH (`CFG_FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (core_r.hold_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (core_r.hold_byte),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // core-domain next state
  always_comb begin
    core_nxt = core_r;

    // two-flop synchronisers for the asynchronous pins
    core_nxt.pin_meta  = host_pins;
    core_nxt.pin_sync  = core_r.pin_meta;
    core_nxt.data_meta = {config_byte_bus_in[`CFG_BYTE_W-1:1], serial_data_in};
    core_nxt.data_sync = core_r.data_meta;
    core_nxt.ws_prev   = selected && ws_low;

    // the holding byte leaves as soon as the fifo takes it
    if (core_r.hold_valid && fifo_in_ready) begin
      core_nxt.hold_valid = 1'b0;
    end

    // peripheral write capture
    if (wr_take) begin
      core_nxt.hold_valid = 1'b1;
      core_nxt.hold_byte  = core_r.data_sync;
    end

    // status read: D7 is ready, the rest read high
    if (status_read) begin
      core_nxt.bus_oe  = `CFG_BUS_ALL_ON;
      core_nxt.bus_out = {!core_r.hold_valid, `CFG_STATUS_FILL};
    end else begin
      core_nxt.bus_oe  = `CFG_BUS_OFF;
      core_nxt.bus_out = `CFG_BUS_OFF;
    end

    // master parallel: present address, wait for prom and synchroniser, take
    core_nxt.addr_oe = (mode == config_load_pkg::MODE_MASTER_PARALLEL) && !config_done;
    core_nxt.ext_oe  = core_nxt.addr_oe && ext_address_enable;
    if (core_r.addr_oe && !core_r.hold_valid) begin
      if (core_r.settle == `CFG_SETTLE_W'(`CFG_PROM_SETTLE_CYC)) begin
        core_nxt.hold_valid = 1'b1;
        core_nxt.hold_byte  = core_r.data_sync;
        core_nxt.addr       = core_r.addr + 1'b1;
        core_nxt.settle     = '0;
      end else begin
        core_nxt.settle = core_r.settle + 1'b1;
      end
    end

    // bytes assembled on the link side arrive by toggle
    // the byte is read only once the toggle has passed both flops
    core_nxt.rx_meta = link_r.rx_tog;
    core_nxt.rx_sync = core_r.rx_meta;
    core_nxt.rx_seen = core_r.rx_sync;
    // serial input has no flow control, so a byte meeting a full buffer is lost
    if ((core_r.rx_sync != core_r.rx_seen) && mode_stream && !core_r.hold_valid) begin
      core_nxt.hold_valid = 1'b1;
      core_nxt.hold_byte  = link_r.rx_byte;
    end

    // link acknowledge toggle, two flops before the drain compares it
    core_nxt.ack_meta  = link_r.ack_tog;
    core_nxt.ack_sync  = core_r.ack_meta;

    // fifo drain: report the byte and, in master parallel and peripheral modes, hand it to the link shifter
    core_nxt.out_valid = 1'b0;
    if (fifo_out_valid && fifo_out_ready) begin
      core_nxt.out_valid = 1'b1;
      core_nxt.out_byte  = fifo_out_data;
      if (mode_parallel) begin
        core_nxt.xfer_byte = fifo_out_data;
        core_nxt.xfer_req  = !core_r.xfer_req;
      end
    end

    // error flag, output enable and hand-over of the strobe pins
    core_nxt.init_low  = config_error && !config_done;
    core_nxt.dout_oe   = !config_done;
    core_nxt.user_pins = config_done ? core_r.pin_sync : `CFG_PINS_IDLE;

    if (rst) begin
      core_nxt           = '0;
      core_nxt.ws_prev   = 1'b1;
      core_nxt.user_pins = `CFG_PINS_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    core_r <= core_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // link-domain next state
  assign link_mode = config_load_pkg::mode_e'(link_r.mode_sync);

  always_comb begin
    link_nxt = link_r;

    // levels and toggles from the core side, two flops each
    link_nxt.rst_meta  = rst;
    link_nxt.rst_sync  = link_r.rst_meta;
    link_nxt.mode_meta = mode;
    link_nxt.mode_sync = link_r.mode_meta;
    link_nxt.done_meta = config_done;
    link_nxt.done_sync = link_r.done_meta;
    link_nxt.req_meta  = core_r.xfer_req;
    link_nxt.req_sync  = link_r.req_meta;

    // serial input pipeline, sampled on the rising edge
    link_nxt.bit_d1 = serial_data_in;
    link_nxt.bit_d2 = link_r.bit_d1;

    unique case (link_mode)
      config_load_pkg::MODE_SLAVE_SERIAL,
      config_load_pkg::MODE_MASTER_SERIAL: begin
        // bits gather first-received-highest into a byte for the core
        link_nxt.asm_byte = {link_r.asm_byte[`CFG_BYTE_W-2:0], serial_data_in};
        link_nxt.asm_cnt  = link_r.asm_cnt + 1'b1;
        if (link_r.asm_cnt == `CFG_LAST_BIT) begin
          link_nxt.rx_byte = link_nxt.asm_byte;
          link_nxt.rx_tog  = !link_r.rx_tog;
          link_nxt.asm_cnt = '0;
        end
      end
      config_load_pkg::MODE_EXPRESS: begin
        // high select gates byte intake instead of selecting a host access
        if (host_pins.select_active_high && !link_r.done_sync) begin
          link_nxt.rx_byte = {config_byte_bus_in[`CFG_BYTE_W-1:1], serial_data_in};
          link_nxt.rx_tog  = !link_r.rx_tog;
        end
      end
      config_load_pkg::MODE_MASTER_PARALLEL,
      config_load_pkg::MODE_PERIPHERAL: begin
        // load a new byte only after the previous one has left
        // xfer_byte holds still until acknowledged, so it is read directly
        if (link_r.shift_cnt == '0) begin
          if (link_r.req_sync != link_r.req_seen) begin
            link_nxt.shift     = core_r.xfer_byte;
            link_nxt.shift_cnt = `CFG_BITS_PER_BYTE;
            link_nxt.req_seen  = link_r.req_sync;
            link_nxt.ack_tog   = !link_r.ack_tog;
          end
        end else begin
          link_nxt.shift     = {link_r.shift[`CFG_BYTE_W-2:0], 1'b0};
          link_nxt.shift_cnt = link_r.shift_cnt - 1'b1;
        end
      end
      default: begin
        link_nxt.asm_cnt = '0;
      end
    endcase

    if (link_r.rst_sync) begin
      link_nxt          = '0;
      link_nxt.rst_meta = rst;
      link_nxt.rst_sync = link_r.rst_meta;
      // mode copy keeps running so no stale mode is decoded after reset
      link_nxt.mode_meta = mode;
      link_nxt.mode_sync = link_r.mode_meta;
    end
  end

  always_ff @(posedge config_clock) begin
    link_r <= link_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output changes on the falling edge of the configuration clock
  always_comb begin
    if (link_r.rst_sync) begin
      dout_nxt = 1'b1;
    end else begin
      unique case (link_mode)
        config_load_pkg::MODE_EXPRESS: begin
          // downstream device is enabled once this one has finished
          dout_nxt = link_r.done_sync;
        end
        config_load_pkg::MODE_MASTER_PARALLEL,
        config_load_pkg::MODE_PERIPHERAL: begin
          // idle high between bytes, most significant bit first
          dout_nxt = (link_r.shift_cnt != '0) ? link_r.shift[`CFG_BYTE_W-1] : 1'b1;
        end
        default: begin
          // sampled at rise n, second stage at rise n+1, out at fall n+1.5
          dout_nxt = link_r.bit_d2;
        end
      endcase
    end
  end

  always_ff @(negedge config_clock) begin
    dout_r <= dout_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign config_byte_bus.out  = core_r.bus_out;
  assign config_byte_bus.oe   = core_r.bus_oe;
  assign serial_data_out      = dout_r;
  assign serial_data_out_oe   = core_r.dout_oe;
  assign prom_address.base    = core_r.addr[`CFG_ADDR_W-1:0];
  assign prom_address.base_oe = core_r.addr_oe;
  assign prom_address.ext     = core_r.addr[`CFG_ADDR_FULL_W-1:`CFG_ADDR_W];
  assign prom_address.ext_oe  = core_r.ext_oe;
  // open-drain init: only ever pulled low
  assign init_n_out           = 1'b0;
  assign init_n_oe            = core_r.init_low;
  assign user_pins            = config_load_pkg::host_pins_s'(core_r.user_pins);
  assign loaded_byte.valid    = core_r.out_valid;
  assign loaded_byte.data     = core_r.out_byte;
endmodule

/* File: config_load_cfg.svh */
// constants for the configuration load port
`ifndef CONFIG_LOAD_CFG_SVH
`define CONFIG_LOAD_CFG_SVH

`define CFG_BYTE_W          8
`define CFG_ADDR_W          18
`define CFG_ADDR_EXT_W      4
`define CFG_ADDR_FULL_W     22
`define CFG_FIFO_DEPTH      32
`define CFG_MODE_W          3
`define CFG_PIN_W           4
`define CFG_STATUS_FILL     7'h7F
`define CFG_BUS_ALL_ON      8'hFF
`define CFG_BUS_OFF         8'h00
`define CFG_PINS_IDLE       4'hF
`define CFG_CORE_MHZ        50
`define CFG_PROM_SETTLE_NS  100
`define CFG_PROM_SETTLE_CYC ((`CFG_PROM_SETTLE_NS * `CFG_CORE_MHZ + 999) / 1000)
`define CFG_SETTLE_W        8
`define CFG_BIT_CNT_W       4
`define CFG_BITS_PER_BYTE   4'h8
`define CFG_LAST_BIT        4'h7

`endif

/* File: config_load_pkg.sv */
// types shared by the configuration load port
package config_load_pkg;
  `include "config_load_cfg.svh"

  typedef logic [`CFG_BYTE_W-1:0] byte_t;

  typedef enum logic [`CFG_MODE_W-1:0] {
    MODE_SLAVE_SERIAL,
    MODE_MASTER_SERIAL,
    MODE_MASTER_PARALLEL,
    MODE_PERIPHERAL,
    MODE_EXPRESS
  } mode_e;

  typedef struct packed {
    logic select_active_low;
    logic select_active_high;
    logic write_strobe_n;
    logic read_strobe_n;
  } host_pins_s;

  typedef struct packed {
    byte_t out;
    byte_t oe;
  } byte_drive_s;

  typedef struct packed {
    logic [`CFG_ADDR_W-1:0]     base;
    logic                       base_oe;
    logic [`CFG_ADDR_EXT_W-1:0] ext;
    logic                       ext_oe;
  } prom_addr_s;

  typedef struct packed {
    logic  valid;
    byte_t data;
  } byte_beat_s;
endpackage

/* File: config_fifo.sv */
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`include "config_load_cfg.svh"
module config_fifo #(
  parameter int WIDTH = `CFG_BYTE_W,
  parameter int DEPTH = `CFG_FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   count;
  } fifo_state_s;

  fifo_state_s      st_r;
  fifo_state_s      st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  // depth must be a power of two so the pointers wrap by themselves
  assign in_ready  = st_r.count != (PTR_W+1)'(DEPTH);
  assign out_valid = st_r.count != '0;
  assign out_data  = mem[st_r.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  ////////////////////////////////////////////////////////////////////////////
  // pointer and fill bookkeeping
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
    end
    st_nxt.count = st_r.count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    if (rst) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    st_r <= st_nxt;
    if (push) begin
      mem[st_r.wr_ptr] <= in_data;
    end
  end
endmodule

/* File: config_load_assertions.sv */
// concurrent checks on the pins of the configuration load port
`timescale 1ns/1ps
module config_load_assertions (
  input wire logic                    core_clk,
  input wire logic                    rst,
  input wire logic                    config_clock,
  input config_load_pkg::mode_e       mode,
  input wire logic                    config_done,
  input wire logic                    config_error,
  input wire logic                    ext_address_enable,
  input config_load_pkg::host_pins_s  host_pins,
  input wire logic [7:0]              config_byte_bus_in,
  input config_load_pkg::byte_drive_s config_byte_bus,
  input wire logic                    serial_data_in,
  input wire logic                    serial_data_out,
  input wire logic                    serial_data_out_oe,
  input config_load_pkg::prom_addr_s  prom_address,
  input wire logic                    init_n_out,
  input wire logic                    init_n_oe,
  input config_load_pkg::host_pins_s  user_pins,
  input config_load_pkg::byte_beat_s  loaded_byte
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // whole address as one value, the step is checked across the field split
  logic [21:0] addr_full;
  assign addr_full = {prom_address.ext, prom_address.base};
  ////////////////////////////////////////////////////////////////////////////////
  status_fill_a: assert property (
    config_byte_bus.oe != 8'h00 |-> config_byte_bus.oe == 8'hFF
      && config_byte_bus.out[6:0] == 7'h7F) else $error("status drive not all high");
  // strobe held low three samples, so depths two and three both see it
  read_cause_a: assert property (
    $rose(config_byte_bus.oe[7]) |-> !$past(host_pins.read_strobe_n, 2)
      && !$past(host_pins.select_active_low, 3) && $past(host_pins.select_active_high, 3))
    else $error("status drive without selected read");
  write_wins_a: assert property (
    (!host_pins.write_strobe_n)[*5] |-> config_byte_bus.oe == 8'h00)
    else $error("status drive while writing");
  addr_mode_a: assert property (
    prom_address.base_oe |-> $past(mode) == config_load_pkg::MODE_MASTER_PARALLEL)
    else $error("address drive outside master parallel");
  ext_oe_a: assert property (
    prom_address.ext_oe |-> prom_address.base_oe && $past(ext_address_enable))
    else $error("extended address driven when not enabled");
  addr_step_a: assert property (
    prom_address.base_oe && addr_full != $past(addr_full) |-> addr_full == $past(addr_full) + 1)
    else $error("address did not step by one");
  init_follow_a: assert property (
    !$past(rst) |-> init_n_oe == $past(config_error && !config_done) && !init_n_out)
    else $error("init pull does not follow data error");
  user_idle_a: assert property (
    (!config_done)[*2] |=> user_pins == 4'hF) else $error("user pins active before done");
  dout_oe_a: assert property (
    config_done[*2] |=> !serial_data_out_oe) else $error("serial output driven after done");
  cover property ($rose(config_byte_bus.oe[7]));
  cover property (loaded_byte.valid);
  cover property (prom_address.base_oe && addr_full == 22'h000002);
endmodule

bind config_load_port config_load_assertions config_load_assertions_inst (
  .core_clk, .rst, .config_clock, .mode, .config_done, .config_error, .ext_address_enable,
  .host_pins, .config_byte_bus_in, .config_byte_bus, .serial_data_in, .serial_data_out,
  .serial_data_out_oe, .prom_address, .init_n_out, .init_n_oe, .user_pins, .loaded_byte);

/* File: config_prom_model.sv */
// parallel configuration prom answering the port's address bus
`timescale 1ns/1ps
module config_prom_model #(
  parameter int ACCESS_NS = 40
) (
  input  wire logic        base_oe,
  input  wire logic [17:0] address,
  output logic      [7:0]  data
);
  initial data = 8'h00;
  // output garbles while the address settles or goes undriven, a stale byte never passes
  always @(address or base_oe) begin
    data = ~data;
    if (base_oe) begin
      #(ACCESS_NS);
      data = address[7:0] ^ 8'h3C;
    end
  end
endmodule

/* File: tb.sv */
// self-checking bench for the configuration load port
`timescale 1ns/1ps
module tb;
  logic                         core_clk = 1'b0;
  logic                         rst = 1'b1;
  logic                         config_clock = 1'b0;
  config_load_pkg::mode_e       mode = config_load_pkg::MODE_PERIPHERAL;
  logic                         config_done = 1'b0;
  logic                         config_error = 1'b0;
  logic                         ext_address_enable = 1'b0;
  config_load_pkg::host_pins_s  host_pins = 4'hB;
  logic [7:0]                   host_data = 8'h00;
  logic                         sdi = 1'b0;
  logic [7:0]                   prom_data;
  config_load_pkg::byte_drive_s config_byte_bus;
  logic                         serial_data_out;
  logic                         serial_data_out_oe;
  config_load_pkg::prom_addr_s  prom_address;
  logic                         init_n_out;
  logic                         init_n_oe;
  config_load_pkg::host_pins_s  user_pins;
  config_load_pkg::byte_beat_s  loaded_byte;
  int                           failures = 0;
  int                           checks_done = 0;
  logic [7:0]                   got[$];
  logic                         par;
  ////////////////////////////////////////////////////////////////////////////////
  // link clock runs free: the forwarding path needs it to drain the buffer
  always #10 core_clk = ~core_clk;
  always #24 config_clock = ~config_clock;
  // in master parallel the prom owns the data pins, D0 included
  assign par = mode == config_load_pkg::MODE_MASTER_PARALLEL;
  config_load_port config_load_port_inst (
    .core_clk(core_clk), .rst(rst), .config_clock(config_clock), .mode(mode),
    .config_done(config_done), .config_error(config_error),
    .ext_address_enable(ext_address_enable), .host_pins(host_pins),
    .config_byte_bus_in(par ? prom_data : host_data), .config_byte_bus(config_byte_bus),
    .serial_data_in(par ? prom_data[0] : sdi), .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe), .prom_address(prom_address),
    .init_n_out(init_n_out), .init_n_oe(init_n_oe), .user_pins(user_pins),
    .loaded_byte(loaded_byte));
  config_prom_model config_prom_model_inst (
    .base_oe(prom_address.base_oe), .address(prom_address.base), .data(prom_data));
  // every consumed byte is queued for later comparison
  always @(posedge core_clk) if (loaded_byte.valid === 1'b1) got.push_back(loaded_byte.data);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  // reset spans at least four link edges so the link side sees it too
  task automatic start(input config_load_pkg::mode_e m);
    rst = 1'b1;
    mode = m;
    config_done = 1'b0;
    config_error = 1'b0;
    host_pins = 4'hB;
    sdi = 1'b0;
    cyc(8);
    // release within one link period after a link edge, so serial bits line up
    @(posedge config_clock);
    cyc(1);
    rst = 1'b0;
    got.delete();
    cyc(1);
  endtask
  // strobes held five cycles, beyond the synchroniser's two
  task automatic host_access(input logic [7:0] b, input logic [3:0] pins);
    host_data = b;
    host_pins = pins;
    cyc(5);
    host_pins = 4'h7;
    cyc(5);
  endtask
  task automatic read_ready();
    host_pins = 4'h6;
    cyc(5);
    check(config_byte_bus.oe, 8'hFF, "status oe");
    check(config_byte_bus.out, 8'hFF, "ready status");
    host_pins = 4'h7;
    cyc(5);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_periph();
    start(config_load_pkg::MODE_PERIPHERAL);
    check({config_byte_bus.oe, init_n_oe, user_pins}, 13'h000F, "reset outs");
    check({serial_data_out, serial_data_out_oe}, 2'b11, "idle dout");
    read_ready();
    host_access(8'hA7, 4'h5);
    // forwarded byte leaves msb first; bit 7 is high, so bit 6 is the first fall
    @(negedge serial_data_out);
    for (int i = 6; i >= 0; i--) begin
      @(posedge config_clock);
      #2;
      check(serial_data_out, (8'hA6 >> i) & 8'h01, "fwd byte");
    end
    sdi = 1'b1;
    host_access(8'h30, 4'h5);
    read_ready();
    host_data = 8'h55;
    host_pins = 4'h4;
    cyc(5);
    check(config_byte_bus.oe, 8'h00, "both strobes");
    host_pins = 4'h7;
    cyc(5);
    host_access(8'h12, 4'hD);
    host_access(8'h12, 4'h1);
    check(got.size(), 3, "byte count");
    check({got[0], got[1], got[2]}, 24'hA63155, "bytes");
    $display("test peripheral done");
  endtask
  task automatic t_master();
    for (int e = 1; e >= 0; e--) begin
      ext_address_enable = e[0];
      start(config_load_pkg::MODE_MASTER_PARALLEL);
      check(prom_address.base_oe, 1'b1, "addr oe");
      check(prom_address.ext_oe, e[0], "ext oe");
      for (int k = 0; k < 400 && got.size() < 3; k++) cyc(1);
      check(got.size() >= 3, 1'b1, "prom byte count");
      for (int i = 0; i < 3; i++) check(got[i], 8'(i) ^ 8'h3C, "prom byte");
    end
    $display("test master parallel done");
  endtask
  task automatic t_serial();
    logic [15:0] bits;
    bits = 16'hA5C3;
    for (int m = 0; m < 2; m++) begin
      start(m ? config_load_pkg::MODE_MASTER_SERIAL : config_load_pkg::MODE_SLAVE_SERIAL);
      repeat (1) @(posedge config_clock); // first bit counted at third edge
      for (int j = 0; j < 19; j++) begin
        @(posedge config_clock);
        #2;
        if (j >= 3) check(serial_data_out, bits[18 - j], "fwd bit");
        if (j < 16) sdi = bits[15 - j];
      end
      cyc(12);
      check(got.size(), 2, "serial count");
      check({got[0], got[1]}, bits, "serial bytes");
    end
    $display("test serial done");
  endtask
  task automatic t_express();
    start(config_load_pkg::MODE_EXPRESS);
    host_data = 8'h5A;
    sdi = 1'b1;
    host_pins = 4'h3;
    repeat (5) @(posedge config_clock);
    cyc(8);
    check(got.size(), 0, "disabled express");
    @(posedge config_clock);
    #2;
    host_pins = 4'h7;
    repeat (4) @(posedge config_clock);
    #2;
    host_pins = 4'h3;
    cyc(8);
    check(got.size() > 0, 1'b1, "express count");
    check(got[0], 8'h5B, "express byte");
    check(serial_data_out, 1'b0, "chain enable low");
    config_done = 1'b1;
    repeat (6) @(posedge config_clock);
    #2;
    check(serial_data_out, 1'b1, "chain enable high");
    $display("test express done");
  endtask
  task automatic t_done();
    start(config_load_pkg::MODE_PERIPHERAL);
    config_error = 1'b1;
    cyc(3);
    check({init_n_oe, init_n_out}, 2'b10, "init pull");
    config_done = 1'b1;
    host_pins = 4'h9;
    cyc(5);
    check(init_n_oe, 1'b0, "init after done");
    check(user_pins, 4'h9, "user pins");
    host_access(8'h77, 4'h5);
    check(got.size(), 0, "write after done");
    $display("test done pins done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #300000;
    failures++;
    print_verdict();
  end
  initial begin
    t_periph();
    t_master();
    t_serial();
    t_express();
    t_done();
    print_verdict();
  end
endmodule
